/* spi_port_pkg.sv */
// package: register map, field layouts and clock tables of the spi port
package spi_port_pkg;

  // ------------------------------------------------------------------
  // basic types
  // ------------------------------------------------------------------
  typedef logic [7:0] byte_t;
  typedef logic [2:0] addr_t;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam addr_t ADDR_CONTROL_A   = 3'h0;
  localparam addr_t ADDR_CONTROL_B   = 3'h1;
  localparam addr_t ADDR_IRQ_CONTROL = 3'h2;
  localparam addr_t ADDR_IRQ_FLAGS   = 3'h3;
  localparam addr_t ADDR_DATA        = 3'h4;

  // ------------------------------------------------------------------
  // register layouts
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       rsv7;
    logic       data_order_select; // 1: lsb first
    logic       host_select;       // 1: host, 0: client
    logic       clock_double;
    logic       rsv3;
    logic [1:0] clock_prescaler;
    logic       enable;
  } control_a_s;

  typedef struct packed {
    logic       buffer_mode_enable;
    logic       buffer_wait_receive;
    logic [2:0] rsv;
    logic       select_pin_disable;
    logic [1:0] mode;              // [1] idle level, [0] phase
  } control_b_s;

  typedef struct packed {
    logic       transfer_done_irq_enable;
    logic       rsv6;
    logic [4:0] rsv;
    logic       transfer_irq_enable;
  } irq_control_s;

  typedef struct packed {
    logic       transfer_flag;
    logic       transfer_done_flag;
    logic       tx_empty_flag;
    logic [3:0] rsv;
    logic       write_collision_flag;
  } irq_flags_s;

  // serial pins, one bit each
  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
    logic ss;
  } pins_s;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam byte_t CONTROL_A_RST   = 8'h00;
  localparam byte_t CONTROL_B_RST   = 8'h00;
  localparam byte_t IRQ_CONTROL_RST = 8'h00;
  localparam byte_t IRQ_FLAGS_RST   = 8'h20; // transmit buffer empty
  localparam byte_t DATA_RST        = 8'h00;
  localparam pins_s PIN_RST         = 4'h1;  // select idles high

  // ------------------------------------------------------------------
  // sck half period minus one, indexed by prescaler
  // normal: ck/4 ck/16 ck/64 ck/128, double: ck/2 ck/8 ck/32 ck/64
  // ------------------------------------------------------------------
  localparam logic [3:0][6:0] HALF_M1_NORM = {7'h3f, 7'h1f, 7'h07, 7'h01};
  localparam logic [3:0][6:0] HALF_M1_DBL  = {7'h1f, 7'h0f, 7'h03, 7'h00};
  localparam logic [6:0]      HCNT_ONE     = 7'h01;

  // ------------------------------------------------------------------
  // bit timing: eight bits are sixteen sck edges
  // ------------------------------------------------------------------
  localparam logic [3:0] EDGE_FIRST = 4'h0;
  localparam logic [3:0] EDGE_LAST  = 4'hf;
  localparam logic [3:0] EDGE_ONE   = 4'h1;

  // receive fifo occupancy
  localparam logic [1:0] FIFO_EMPTY = 2'h0;
  localparam logic [1:0] FIFO_ONE   = 2'h1;
  localparam logic [1:0] FIFO_FULL  = 2'h2;

  // host sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_SHIFT} host_state_e;

endpackage

/* spi_host_client_port.sv */
// spi host/client port: registers, shift engine, pins and flags
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps

// Operation
// R1: host drops select before first sck edge
// R2: mosi host-to-client, miso client-to-host, same pulses
// R3: one 8-bit register shifts out and in
// R4: data write loads shifter or transmit buffer
// R5: data read gives receive reg or fifo
// R6: host divides sck, client syncs incoming sck
// R7: output-direction pins driven by serial logic
// R8: input-role pins forced to input when enabled
// R9: client miso driven only while select low
// R10: host data write starts a transfer
// R11: early host write corrupts, sets collision flag
// R12: host normal receive byte latched at end
// R13: transfer flag set, gated interrupt request
// R14: buffer bit selects buffer mode, wait ignored
// R15: host buffer: send now, hold next
// R16: buffer mode receive through two-entry fifo
// R17: done flag when shifter and buffer empty
// R18: software writes enable bit last
// R19: sck rate from prescaler and double bit
// R20: bit order and mode are selectable
// R21: select-disable frees select pin from logic
// R22: select low in host: become client, flag
// R23: empty flag falls on write, rises on copy
// R24: seven rates, fastest is clock over two
// R25: mode gives idle polarity and sample phase
// R26: sck idles between transfers, eight bits each
module spi_host_client_port
  import spi_port_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  sys_rst,
  input  wire addr_t addr,
  input  wire byte_t wr_data,
  input  wire logic  wr_en,
  input  wire logic  rd_en,
  output byte_t      rd_data,
  input  wire pins_s pin_in,
  input  wire pins_s pin_dir,
  output pins_s      pin_out,
  output pins_s      pin_oe,
  input  wire logic  global_irq_en,
  output logic       irq
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  control_a_s   ctl_a_r;     // enable, role, rate, order
  control_b_s   ctl_b_r;     // mode, buffering, select use
  irq_control_s irqc_r;      // interrupt enables
  irq_flags_s   flags_r;     // sticky status
  byte_t        sr_r;        // shift register
  byte_t        txb_r;       // transmit buffer
  byte_t        rx_r;        // normal mode receive register
  byte_t        fifo_r [2];  // buffer mode receive fifo
  logic [1:0]   fcnt_r;      // fifo occupancy
  logic         samp_r;      // bit sampled, waiting to shift
  host_state_e  st_r;        // host sequencer
  logic [6:0]   hcnt_r;      // half period counter
  logic [3:0]   edge_r;      // sck edge index in the byte
  logic         sck_r;       // host sck level
  logic         sck_prev_r;  // last filtered client sck
  pins_s        s1_r;        // pin sync stage 1
  pins_s        s2_r;        // pin sync stage 2
  pins_s        s3_r;        // pin sync stage 3
  pins_s        pf_r;        // filtered pin levels
  byte_t        rd_data_r;
  pins_s        pin_out_r;
  pins_s        pin_oe_r;
  logic         irq_r;

  assign rd_data = rd_data_r;
  assign pin_out = pin_out_r;
  assign pin_oe  = pin_oe_r;
  assign irq     = irq_r;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  logic       en, host, cpol, cpha, lsb, bufm;
  logic [6:0] half_m1;
  logic       wr_dat, rd_dat, host_busy, cli_busy;
  logic       tick_h, tick_c, edge_ev, lead, last;
  logic       do_samp, do_shift, in_bit;
  byte_t      shifted;
  logic       mh_lose, h_start, to_txb, collide;
  logic       ld_sr, refill, push, pop;

  assign en   = ctl_a_r.enable;
  assign host = ctl_a_r.host_select;
  // R25: mode idle level and phase
  assign cpol = ctl_b_r.mode[1];
  assign cpha = ctl_b_r.mode[0];
  // R20: bit order choice
  assign lsb  = ctl_a_r.data_order_select;
  // R14: buffer mode, wait bit unused
  assign bufm = ctl_b_r.buffer_mode_enable;

  // R19: rate from prescaler and double
  // R24: seven distinct rates
  assign half_m1 = ctl_a_r.clock_double
                 ? HALF_M1_DBL[ctl_a_r.clock_prescaler]
                 : HALF_M1_NORM[ctl_a_r.clock_prescaler];

  assign wr_dat    = wr_en && (addr == ADDR_DATA);
  assign rd_dat    = rd_en && (addr == ADDR_DATA);
  assign host_busy = (st_r != ST_IDLE);
  assign cli_busy  = !pf_r.ss && (edge_r != EDGE_FIRST);

  // R6: host divider tick, client sck edge
  assign tick_h  = host && host_busy && (hcnt_r == half_m1);
  assign tick_c  = en && !host && !pf_r.ss && (pf_r.sck != sck_prev_r);
  assign edge_ev = (tick_h && (st_r == ST_SHIFT)) || tick_c;
  assign lead    = ~edge_r[0];
  assign last    = edge_ev && (edge_r == EDGE_LAST);

  // R25: phase 0 samples leading, phase 1 trailing
  assign do_samp  = edge_ev && (lead ^ cpha);
  assign do_shift = edge_ev && (cpha ? ((lead && edge_r != EDGE_FIRST)
                                       || last) : !lead);
  // R2: host reads miso, client reads mosi
  assign in_bit  = do_samp ? (host ? pf_r.miso : pf_r.mosi) : samp_r;
  // R3: out one end, in the other
  assign shifted = lsb ? {in_bit, sr_r[7:1]} : {sr_r[6:0], in_bit};

  // R22: another host pulls select low
  // R21: select-disable masks this
  assign mh_lose = en && host && !ctl_b_r.select_pin_disable
                && !pin_dir.ss && !pf_r.ss;

  // R10: host write starts a byte
  // R15: idle buffer-mode write goes out at once
  assign h_start = wr_dat && en && host && !host_busy
                && (!bufm || flags_r.tx_empty_flag);
  // R15: later writes wait in the buffer
  assign to_txb  = wr_dat && bufm && flags_r.tx_empty_flag && !h_start;
  // R11: write during a normal-mode transfer
  assign collide = wr_dat && en && !bufm && (host ? host_busy : cli_busy);
  // R4: normal writes hit the shifter
  assign ld_sr   = h_start || (wr_dat && !bufm && (host || !cli_busy));
  assign refill  = last && bufm && !flags_r.tx_empty_flag;
  assign push    = last && bufm;
  assign pop     = rd_dat && bufm && (fcnt_r != FIFO_EMPTY);

  // ------------------------------------------------------------------
  // pin synchroniser and filter
  // ------------------------------------------------------------------
  // a level counts once stages two and three agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
      s3_r <= PIN_RST;
      pf_r <= PIN_RST;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pf_r <= pins_s'((s2_r & s3_r) | (pf_r & (s2_r | s3_r)));
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_a_r <= CONTROL_A_RST;
      ctl_b_r <= CONTROL_B_RST;
      irqc_r  <= IRQ_CONTROL_RST;
    end else begin
      if (wr_en && addr == ADDR_CONTROL_A) begin
        ctl_a_r <= wr_data;
      end
      if (wr_en && addr == ADDR_CONTROL_B) begin
        ctl_b_r <= wr_data;
      end
      if (wr_en && addr == ADDR_IRQ_CONTROL) begin
        irqc_r <= wr_data;
      end
      // R22: lost arbitration drops to client
      if (mh_lose) begin
        ctl_a_r.host_select <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // host sequencer and sck divider
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
    end else if (mh_lose || !en || !host) begin
      st_r <= ST_IDLE;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (h_start) begin
            st_r <= ST_SETUP;
          end
        end
        // R1: half period in setup, so select is low a full sck period before the first edge
        ST_SETUP: begin
          if (tick_h) begin
            st_r <= ST_SHIFT;
          end
        end
        // R26: eight bits, then stop or refill
        ST_SHIFT: begin
          if (last) begin
            st_r <= refill ? ST_SETUP : ST_IDLE;
          end
        end
      endcase
    end
  end

  // half period counter restarts on each tick
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hcnt_r <= '0;
    end else if (!host_busy || tick_h) begin
      hcnt_r <= '0;
    end else begin
      hcnt_r <= hcnt_r + HCNT_ONE;
    end
  end

  // edge index; select high drops a partial client byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_r <= EDGE_FIRST;
    end else if ((host && st_r != ST_SHIFT) || (!host && pf_r.ss)) begin
      edge_r <= EDGE_FIRST;
    end else if (edge_ev) begin
      edge_r <= edge_r + EDGE_ONE;
    end
  end

  // R26: sck rests at idle level outside shifting
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_r      <= 1'b0;
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= pf_r.sck;
      if (st_r != ST_SHIFT) begin
        sck_r <= cpol;
      end else if (edge_ev) begin
        sck_r <= ~sck_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // data path
  // ------------------------------------------------------------------
  // R3: shifter, write load wins over a shift
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sr_r   <= DATA_RST;
      samp_r <= 1'b0;
      txb_r  <= DATA_RST;
      rx_r   <= DATA_RST;
    end else begin
      if (do_samp) begin
        samp_r <= in_bit;
      end
      if (ld_sr) begin
        sr_r <= wr_data;
      end else if (refill) begin
        sr_r <= txb_r;
      end else if (do_shift) begin
        sr_r <= shifted;
      end
      // R4: buffer mode writes go to the buffer
      if (to_txb) begin
        txb_r <= wr_data;
      end
      // R12: received byte latched at end
      if (last && !bufm) begin
        rx_r <= shifted;
      end
    end
  end

  // R16: two-entry receive fifo, full drops new
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fcnt_r    <= FIFO_EMPTY;
      fifo_r[0] <= DATA_RST;
      fifo_r[1] <= DATA_RST;
    end else if (push && pop) begin
      if (fcnt_r == FIFO_ONE) begin
        fifo_r[0] <= shifted;
      end else begin
        fifo_r[0] <= fifo_r[1];
        fifo_r[1] <= shifted;
      end
    end else if (push) begin
      if (fcnt_r == FIFO_EMPTY) begin
        fifo_r[0] <= shifted;
        fcnt_r    <= FIFO_ONE;
      end else if (fcnt_r == FIFO_ONE) begin
        fifo_r[1] <= shifted;
        fcnt_r    <= FIFO_FULL;
      end
    end else if (pop) begin
      fifo_r[0] <= fifo_r[1];
      fcnt_r    <= fcnt_r - FIFO_ONE;
    end
  end

  // ------------------------------------------------------------------
  // status flags: hardware set wins over write-one clear
  // ------------------------------------------------------------------
  irq_flags_s clr;
  assign clr = (wr_en && addr == ADDR_IRQ_FLAGS) ? wr_data : '0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= IRQ_FLAGS_RST;
    end else begin
      // R13: every finished byte, R22 lost arbitration
      flags_r.transfer_flag <= last || mh_lose
        || (flags_r.transfer_flag && !clr.transfer_flag);
      // R11: collision is sticky
      flags_r.write_collision_flag <= collide
        || (flags_r.write_collision_flag && !clr.write_collision_flag);
      // R17: nothing left to send
      flags_r.transfer_done_flag <= (last && bufm
                                     && flags_r.tx_empty_flag)
        || (flags_r.transfer_done_flag && !clr.transfer_done_flag);
      // R23: falls on buffer write, rises on copy
      if (to_txb) begin
        flags_r.tx_empty_flag <= 1'b0;
      end else if (refill) begin
        flags_r.tx_empty_flag <= 1'b1;
      end
    end
  end

  // R13: request gated by local and global enables
  // R17: done request likewise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= global_irq_en
            && ((irqc_r.transfer_irq_enable && flags_r.transfer_flag)
            || (irqc_r.transfer_done_irq_enable
                && flags_r.transfer_done_flag));
    end
  end

  // ------------------------------------------------------------------
  // register read port, data valid one cycle after the strobe
  // ------------------------------------------------------------------
  // R5: data read picks register or fifo head
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_r <= DATA_RST;
    end else if (!rd_en) begin
      rd_data_r <= DATA_RST;
    end else begin
      case (addr)
        ADDR_CONTROL_A:   rd_data_r <= ctl_a_r;
        ADDR_CONTROL_B:   rd_data_r <= ctl_b_r;
        ADDR_IRQ_CONTROL: rd_data_r <= irqc_r;
        ADDR_IRQ_FLAGS:   rd_data_r <= flags_r;
        ADDR_DATA:        rd_data_r <= bufm ? fifo_r[0] : rx_r;
        default:          rd_data_r <= DATA_RST;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------------
  // R7: output-direction pins follow the serial logic
  // R8: input-role pins never driven while enabled
  // R9: client miso released while select high
  // R1: host select low for the whole transfer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out_r <= PIN_RST;
      pin_oe_r  <= '0;
    end else begin
      pin_out_r.mosi <= lsb ? sr_r[0] : sr_r[7];
      pin_out_r.miso <= lsb ? sr_r[0] : sr_r[7];
      pin_out_r.sck  <= sck_r;
      pin_out_r.ss   <= !host_busy;
      pin_oe_r.mosi  <= en && host && pin_dir.mosi;
      pin_oe_r.sck   <= en && host && pin_dir.sck;
      pin_oe_r.ss    <= en && host && pin_dir.ss;
      pin_oe_r.miso  <= en && !host && pin_dir.miso && !pf_r.ss;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_host_miso_in;
    en && host |=> !pin_oe_r.miso;
  endproperty
  a_host_miso_in: assert property (p_host_miso_in) // R8
    else $error("miso driven in host mode");

  property p_cli_miso_off;
    en && !host && pf_r.ss |=> !pin_oe_r.miso;
  endproperty
  a_cli_miso_off: assert property (p_cli_miso_off) // R9
    else $error("miso driven with select high");

  property p_wcol;
    en && host && !bufm && wr_dat && host_busy
      |=> flags_r.write_collision_flag;
  endproperty
  a_wcol: assert property (p_wcol) // R11
    else $error("collision flag not set");

  property p_start;
    en && host && !bufm && wr_dat && !host_busy && !mh_lose
      |=> st_r == ST_SETUP;
  endproperty
  a_start: assert property (p_start) // R10
    else $error("host write did not start transfer");

  property p_rx;
    last && !bufm |=> rx_r == $past(shifted);
  endproperty
  a_rx: assert property (p_rx) // R12
    else $error("receive byte not latched");

  property p_txe_fall;
    to_txb |=> !flags_r.tx_empty_flag;
  endproperty
  a_txe_fall: assert property (p_txe_fall) // R23
    else $error("empty flag did not fall");

  property p_done;
    last && bufm && flags_r.tx_empty_flag
      |=> flags_r.transfer_done_flag;
  endproperty
  a_done: assert property (p_done) // R17
    else $error("done flag not set");

  property p_lose;
    mh_lose |=> !ctl_a_r.host_select && flags_r.transfer_flag;
  endproperty
  a_lose: assert property (p_lose) // R22
    else $error("select low did not demote host");

  property p_idle_sck;
    (en && host && !host_busy && $stable(ctl_b_r)) [*3]
      |-> pin_out_r.sck == cpol;
  endproperty
  a_idle_sck: assert property (p_idle_sck) // R26
    else $error("sck not at idle level");

  property p_irq;
    flags_r.transfer_flag && irqc_r.transfer_irq_enable
      && global_irq_en |=> irq_r;
  endproperty
  a_irq: assert property (p_irq) // R13
    else $error("transfer interrupt missing");

  property p_fifo;
    push && !pop && fcnt_r == FIFO_EMPTY
      |=> fcnt_r == FIFO_ONE && fifo_r[0] == $past(shifted);
  endproperty
  a_fifo: assert property (p_fifo) // R16
    else $error("fifo push lost");

  c_host_done: cover property (host && last && !bufm);
  c_refill:    cover property (refill);
  c_lose:      cover property (mh_lose);
  c_cli_done:  cover property (!host && last);

endmodule

/* spi_client_model.sv */
// client model: mode 0 spi client that answers every byte
`timescale 1ns/1ps
module spi_client_model (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       lsb_first,
  input  wire logic [7:0] base,
  output logic            miso,
  output logic [7:0]      got,
  output int              nbytes
);
  logic [7:0] tx;  // outgoing byte
  logic [7:0] rx;  // incoming byte
  int         cnt; // bits of the current byte
  initial begin
    nbytes = 0;
    cnt = 0;
    miso = 1'b1;
    got = 8'h00;
    tx = 8'h00;
    rx = 8'h00;
  end
  always @(negedge sel_n) begin
    cnt = 0;
    tx = base + nbytes[7:0];
    miso = lsb_first ? tx[0] : tx[7];
  end
  // sample mosi on the leading edge
  always @(posedge sclk) if (!sel_n) begin
    rx = lsb_first ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    cnt = cnt + 1;
    if (cnt == 8) begin
      got = rx;
      cnt = 0;
      nbytes = nbytes + 1;
    end
  end
  // next bit on trailing edge, reload after eight
  always @(negedge sclk) if (!sel_n) begin
    if (cnt == 0) tx = base + nbytes[7:0];
    else tx = lsb_first ? tx >> 1 : tx << 1;
    miso = lsb_first ? tx[0] : tx[7];
  end
  // released line shows the inverse of its last bit
  always @(posedge sel_n) miso = ~miso;
endmodule

/* tb_spi_host_client_port.sv */
// testbench: host transfers against the client model
`timescale 1ns/1ps
module tb_spi_host_client_port import spi_port_pkg::*;;
  logic  clk, sys_rst, wr_en, rd_en, gie, ss_in, cmiso, lsb, irq;
  addr_t addr;
  byte_t wr_data, rd_data, got, v, d, base;
  pins_s pin_in, pin_dir, pin_out, pin_oe;
  int    err_count, n_compared, seed, nb, k, nbytes;
  byte_t exp_q[$]; // expected receive bytes
  byte_t rst_v[6] = '{CONTROL_A_RST, CONTROL_B_RST, IRQ_CONTROL_RST,
                      IRQ_FLAGS_RST, DATA_RST, 8'h00};
  assign pin_in = {pin_out.mosi, cmiso, pin_out.sck, ss_in};
  spi_host_client_port uut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .pin_in(pin_in), .pin_dir(pin_dir), .pin_out(pin_out),
    .pin_oe(pin_oe), .global_irq_en(gie), .irq(irq));
  spi_client_model cli (.sclk(pin_oe.sck & pin_out.sck),
    .sel_n(pin_oe.ss ? pin_out.ss : 1'b1), .mosi(pin_out.mosi),
    .lsb_first(lsb), .base(base), .miso(cmiso), .got(got),
    .nbytes(nbytes));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input byte_t s, input byte_t e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input addr_t a, input byte_t x);
    @(posedge clk);
    addr <= a;
    wr_data <= x;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input addr_t a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  // poll the flags until any bit of m is set
  task automatic wait_flag(input byte_t m);
    k = 0;
    do begin
      rd(ADDR_IRQ_FLAGS);
      k++;
    end while ((v & m) == 8'h00 && k < 400);
    chk("flag", v & m, m);
  endtask
  // one normal host transfer and its answers
  task automatic xfer(input byte_t x);
    exp_q.push_back(base + nb[7:0]);
    nb++;
    wr(ADDR_DATA, x);
    wait_flag(8'h80);
    chk("client_rx", got, x);
    chk("irq", {7'h00, irq}, 8'h01);
    rd(ADDR_DATA);
    chk("rx", v, exp_q.pop_front());
    wr(ADDR_IRQ_FLAGS, 8'h80);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
  initial begin
    {wr_en, rd_en, lsb} = 3'h0;
    {gie, ss_in, sys_rst} = 3'h7;
    addr = 3'h0;
    wr_data = 8'h00;
    pin_dir = 4'hb;
    base = 8'h5a;
    seed = 43;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped address
    for (int a = 0; a < 6; a++) begin
      rd(addr_t'(a));
      chk("reset", v, rst_v[a]);
    end
    wr(ADDR_IRQ_CONTROL, 8'h81);
    wr(ADDR_CONTROL_A, 8'h23);
    for (int i = 0; i < 4; i++) xfer(byte_t'($random(seed)));
    // premature write during a transfer
    wr(ADDR_DATA, byte_t'($random(seed)));
    wr(ADDR_DATA, 8'h3c);
    exp_q.push_back(base + nb[7:0]);
    nb++;
    wait_flag(8'h80);
    chk("collision", v & 8'h81, 8'h81);
    rd(ADDR_DATA);
    chk("rx_col", v, exp_q.pop_front());
    wr(ADDR_IRQ_FLAGS, 8'h81);
    // lsb first order
    wr(ADDR_CONTROL_A, 8'h63);
    lsb = 1'b1;
    for (int i = 0; i < 2; i++) xfer(byte_t'($random(seed)));
    wr(ADDR_CONTROL_A, 8'h23);
    lsb = 1'b0;
    // buffer mode: two queued bytes, fifo read; enable written last
    wr(ADDR_CONTROL_A, 8'h22);
    wr(ADDR_CONTROL_B, 8'hc0);
    wr(ADDR_CONTROL_A, 8'h23);
    d = byte_t'($random(seed));
    wr(ADDR_DATA, d);
    wr(ADDR_DATA, 8'ha5);
    rd(ADDR_IRQ_FLAGS);
    chk("tx_empty", v & 8'h20, 8'h00);
    exp_q.push_back(base + nb[7:0]);
    exp_q.push_back(base + nb[7:0] + 8'h01);
    nb += 2;
    wait_flag(8'h40);
    chk("client_rx2", got, 8'ha5);
    chk("done_irq", {7'h00, irq}, 8'h01);
    for (int i = 0; i < 2; i++) begin
      rd(ADDR_DATA);
      chk("fifo", v, exp_q.pop_front());
    end
    wr(ADDR_CONTROL_B, 8'h04);
    // another host pulls select low, ignored while select is disabled
    wr(ADDR_IRQ_FLAGS, 8'hc1);
    pin_dir <= 4'ha;
    ss_in <= 1'b0;
    repeat (10) @(posedge clk);
    rd(ADDR_CONTROL_A);
    chk("host_kept", v, 8'h23);
    wr(ADDR_CONTROL_B, 8'h00);
    repeat (10) @(posedge clk);
    rd(ADDR_CONTROL_A);
    chk("host_lost", v, 8'h03);
    rd(ADDR_IRQ_FLAGS);
    chk("lost_flag", v & 8'h80, 8'h80);
    chk("count", byte_t'(nbytes), byte_t'(nb));
    end_sim();
  end
endmodule
